// ==== design/flash_seq_pkg.sv ====
// Shared constants and types for the flash command sequencer
package flash_seq_pkg;
  // Command codes, low byte of the 16-bit write
  localparam logic [7:0] CMD_READ_ARRAY   = 8'hFF;
  localparam logic [7:0] CMD_READ_STATUS  = 8'h70;
  localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
  localparam logic [7:0] CMD_PROGRAM      = 8'h41;
  localparam logic [7:0] CMD_BLOCK_ERASE  = 8'h20;
  localparam logic [7:0] CMD_LOCK_PROGRAM = 8'h77;
  localparam logic [7:0] CMD_READ_LOCK    = 8'h71;
  localparam logic [7:0] CMD_BLANK_CHECK  = 8'h25;
  localparam logic [7:0] CMD_CONFIRM      = 8'hD0;
  // Status byte layout and reset values
  localparam int unsigned STS_PROG_BIT   = 4;
  localparam int unsigned STS_ERASE_BIT  = 5;
  localparam int unsigned STS_READY_BIT  = 7;
  localparam logic        STS_PROG_RST   = 1'b0;
  localparam logic        STS_ERASE_RST  = 1'b0;
  localparam logic        LOCK_STATE_RST = 1'b1;
  localparam logic        LOCK_BIT_RST   = 1'b1;
  // Timing, in ns and derived cycles
  localparam int unsigned CLK_PERIOD_NS   = 10;
  localparam int unsigned OP_TIME_NS      = 2000;
  localparam int unsigned RESTART_TIME_NS = 500;
  localparam int unsigned OP_CYCLES       = (OP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RESTART_CYCLES  =
    (RESTART_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned TIMER_W         = 12;
  // Sequencer states, Gray codes in declaration order
  typedef enum logic [2:0] {
    ST_READY   = 3'h0,
    ST_WAIT2   = 3'h1,
    ST_PROG_W1 = 3'h3,
    ST_PROG_W2 = 3'h2,
    ST_BUSY    = 3'h6,
    ST_SUSPEND = 3'h7,
    ST_RESTART = 3'h5
  } seq_state_t;
  // Operation kinds handed to the array
  typedef enum logic [2:0] {
    OP_NONE      = 3'h0,
    OP_PROGRAM   = 3'h1,
    OP_ERASE     = 3'h2,
    OP_LOCK_PROG = 3'h3,
    OP_READ_LOCK = 3'h4,
    OP_BLANK     = 3'h5
  } op_kind_t;
endpackage : flash_seq_pkg

// ==== design/op_cycle_timer.sv ====
// Down-counter timing array operations and flash restart
module op_cycle_timer #(
  parameter int unsigned W = 12
) (
  // Clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_rst_b,
  // Control
  input  wire logic         i_load,
  input  wire logic [W-1:0] i_count,
  input  wire logic         i_run,
  // Status
  output logic              o_expired
);
  logic [W-1:0] cnt_reg;

  // Load wins over counting; holds while not running (suspend)
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cnt_reg <= '0;
    end else if (i_load) begin
      cnt_reg <= i_count;
    end else if (i_run && cnt_reg != '0) begin
      cnt_reg <= cnt_reg - W'(1);
    end
  end

  assign o_expired = (cnt_reg == '0);
endmodule : op_cycle_timer

// ==== design/lock_bit_store.sv ====
// Per-block lock indicators, 1 unlocked, 0 locked
module lock_bit_store #(
  parameter int unsigned BLOCKS = 16,
  parameter int unsigned IDX_W  = 4
) (
  // Clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_rst_b,
  // Access
  input  wire logic [IDX_W-1:0] i_idx,
  input  wire logic             i_clear,
  input  wire logic             i_set,
  output logic                  o_bit
);
  import flash_seq_pkg::*;
  logic [BLOCKS-1:0] lock_reg;

  // One indicator per block; clear means locked
  for (genvar b = 0; b < BLOCKS; b++) begin : g_blk
    always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
        lock_reg[b] <= LOCK_BIT_RST;
      end else if (i_idx == IDX_W'(b)) begin
        if (i_clear) begin
          lock_reg[b] <= 1'b0;
        end else if (i_set) begin
          lock_reg[b] <= 1'b1;
        end
      end
    end
  end

  assign o_bit = lock_reg[i_idx];
endmodule : lock_bit_store

// ==== design/flash_lock_blank_status_sequencer.sv ====
// Flash command sequencer: lock, blank check, status and suspend
// Summary of operation
// - 77h then D0h at block top address clears that block's lock indicator.
// - Ready flag is low while a lock program runs, high when done.
// - 71h then D0h at block top copies that block's lock indicator to lock flag.
// - 25h then D0h at block top checks blankness; non-blank sets erase error.
// - Blank check on a locked block sets erase error, regardless of lock disable.
// - Status byte: bit 4 program error, bit 5 erase error, bit 7 ready.
// - After program, erase, lock program or blank commands even-address reads return status until FFh or a forced stop.
// - Both error flags mean sequence error; one alone means that error.
// - Bad command or second-cycle data not D0h/FFh after 20h, 77h, 71h or 25h sets both error flags.
// - FFh in the second cycle of 20h, 77h, 71h or 25h drops the pending command and selects array reads.
// - Erase error on locked erase, failed erase verify, or non-blank check.
// - Program error on locked program, failed verify, or failed lock write.
// - Lock disable suppresses locked erase/program and failed lock-write errors.
// - Commands accepted only with rewrite enable; mode select 0 keeps CPU running.
// - Suspend request during program or erase suspends after a latency; clearing resumes.
// - Forced-stop interrupt aborts the operation, resets, restarts after a delay.
// - In CPU-running mode the watchdog keeps counting during operations.
// - 50h clears both error flags.
// - 70h makes the following even-address read return the status byte.
module flash_lock_blank_status_sequencer
  import flash_seq_pkg::*;
#(
  parameter int unsigned ADDR_W         = 20,
  parameter int unsigned BLOCK_SHIFT    = 12,
  parameter int unsigned BLOCKS         = 16,
  parameter int unsigned SUSPEND_CYCLES = 20
) (
  // Clock and reset
  input  wire logic                       i_clk,
  input  wire logic                       i_rst_b,
  // CPU flash access
  input  wire logic                       i_bus_we,
  input  wire logic                       i_bus_re,
  input  wire logic [ADDR_W-1:0]          i_bus_addr,
  input  wire logic [15:0]                i_bus_wdata,
  output logic      [15:0]                o_bus_rdata,
  // Flash array macro
  input  wire logic [15:0]                i_array_rdata,
  input  wire logic                       i_blank_result,
  input  wire logic                       i_verify_fail,
  output logic                            o_array_start,
  output flash_seq_pkg::op_kind_t         o_array_kind,
  output logic      [$clog2(BLOCKS)-1:0]  o_array_block,
  // Control bits
  input  wire logic                       i_rewrite_enable_bit,
  input  wire logic                       i_rewrite_mode_select_bit,
  input  wire logic                       i_lock_disable_bit,
  input  wire logic                       i_suspend_request_bit,
  input  wire logic                       i_forced_stop,
  // Status
  output logic                            o_sequencer_ready_flag,
  output logic                            o_program_error_flag,
  output logic                            o_erase_error_flag,
  output logic                            o_lock_state_flag,
  output logic                            o_suspended,
  output logic      [7:0]                 o_flash_sequencer_status_byte,
  output logic                            o_watchdog_count_en
);
  import flash_seq_pkg::*;

  localparam int unsigned IDX_W = $clog2(BLOCKS);
  localparam int unsigned LAT_W = $clog2(SUSPEND_CYCLES + 1);

  seq_state_t        state_reg, state_next;
  op_kind_t          pend_reg, pend_next;
  op_kind_t          kind_reg;
  logic [ADDR_W-1:0] first_addr_reg;
  logic [IDX_W-1:0]  block_reg, block_next;
  logic              status_mode_reg, status_mode_next;
  logic              prog_err_reg, erase_err_reg, lock_state_reg;
  logic [LAT_W-1:0]  lat_cnt_reg;
  logic [15:0]       rdata_reg;
  logic              start_reg;
  logic              prog_set, erase_set, err_clr, lock_load;
  logic              lock_clr, lock_set, start_op;
  logic              timer_load, timer_expired;
  logic [TIMER_W-1:0] timer_count;
  logic              lock_bit;
  logic              cmd_wr, top_addr, op_done, lat_done;
  logic [7:0]        code;
  logic [IDX_W-1:0]  addr_idx;

  // Commands only count while rewrite is enabled
  assign cmd_wr   = i_bus_we && i_rewrite_enable_bit;
  assign code     = i_bus_wdata[7:0];
  assign addr_idx = i_bus_addr[BLOCK_SHIFT +: IDX_W];
  // Block operand must be the highest even address of its block
  assign top_addr = (&i_bus_addr[BLOCK_SHIFT-1:1]) && !i_bus_addr[0];
  assign op_done  = (state_reg == ST_BUSY) && timer_expired && !i_forced_stop;
  assign lat_done = (lat_cnt_reg == LAT_W'(SUSPEND_CYCLES));

  lock_bit_store #(
    .BLOCKS (BLOCKS),
    .IDX_W  (IDX_W)
  ) u_locks (
    .i_clk   (i_clk),
    .i_rst_b (i_rst_b),
    .i_idx   (block_reg),
    .i_clear (lock_clr),
    .i_set   (lock_set),
    .o_bit   (lock_bit)
  );

  op_cycle_timer #(
    .W (TIMER_W)
  ) u_timer (
    .i_clk     (i_clk),
    .i_rst_b   (i_rst_b),
    .i_load    (timer_load),
    .i_count   (timer_count),
    .i_run     (state_reg == ST_BUSY || state_reg == ST_RESTART),
    .o_expired (timer_expired)
  );

  // Command decode and sequencing
  always_comb begin
    state_next       = state_reg;
    pend_next        = pend_reg;
    block_next       = block_reg;
    status_mode_next = status_mode_reg;
    prog_set         = 1'b0;
    erase_set        = 1'b0;
    err_clr          = 1'b0;
    lock_load        = 1'b0;
    lock_clr         = 1'b0;
    lock_set         = 1'b0;
    start_op         = 1'b0;
    timer_load       = 1'b0;
    timer_count      = TIMER_W'(OP_CYCLES);
    case (state_reg)
      ST_READY: begin
        if (cmd_wr) begin
          case (code)
            CMD_READ_ARRAY:   status_mode_next = 1'b0;
            CMD_READ_STATUS:  status_mode_next = 1'b1;
            CMD_CLEAR_STATUS: err_clr = 1'b1;
            CMD_PROGRAM:      state_next = ST_PROG_W1;
            CMD_BLOCK_ERASE: begin
              pend_next  = OP_ERASE;
              state_next = ST_WAIT2;
            end
            CMD_LOCK_PROGRAM: begin
              pend_next  = OP_LOCK_PROG;
              state_next = ST_WAIT2;
            end
            CMD_READ_LOCK: begin
              pend_next  = OP_READ_LOCK;
              state_next = ST_WAIT2;
            end
            CMD_BLANK_CHECK: begin
              pend_next  = OP_BLANK;
              state_next = ST_WAIT2;
            end
            default: begin
              // Unknown code is a sequence error
              prog_set  = 1'b1;
              erase_set = 1'b1;
              status_mode_next = 1'b1;
            end
          endcase
        end
      end
      ST_WAIT2: begin
        if (cmd_wr) begin
          state_next = ST_READY;
          block_next = addr_idx;
          if (code == CMD_READ_ARRAY) begin
            status_mode_next = 1'b0;
          end else if (code != CMD_CONFIRM || !top_addr ||
                       (pend_reg == OP_LOCK_PROG && i_bus_addr != first_addr_reg)) begin
            prog_set  = 1'b1;
            erase_set = 1'b1;
            status_mode_next = 1'b1;
          end else begin
            if (pend_reg != OP_READ_LOCK) begin
              status_mode_next = 1'b1;
            end
            start_op   = 1'b1;
            timer_load = 1'b1;
            state_next = ST_BUSY;
          end
        end
      end
      ST_PROG_W1: begin
        if (cmd_wr) begin
          block_next = addr_idx;
          state_next = ST_PROG_W2;
        end
      end
      ST_PROG_W2: begin
        if (cmd_wr) begin
          pend_next        = OP_PROGRAM;
          status_mode_next = 1'b1;
          start_op         = 1'b1;
          timer_load       = 1'b1;
          state_next       = ST_BUSY;
        end
      end
      ST_BUSY: begin
        if (i_forced_stop) begin
          // Abort at once and hold the flash in reset
          timer_load  = 1'b1;
          timer_count = TIMER_W'(RESTART_CYCLES);
          state_next  = ST_RESTART;
        end else if (i_suspend_request_bit && lat_done &&
                     (kind_reg == OP_PROGRAM || kind_reg == OP_ERASE)) begin
          state_next = ST_SUSPEND;
        end else if (timer_expired) begin
          state_next = ST_READY;
          case (kind_reg)
            OP_LOCK_PROG: begin
              if (i_verify_fail) begin
                prog_set = !i_lock_disable_bit;
              end else begin
                lock_clr = 1'b1;
              end
            end
            OP_READ_LOCK: lock_load = 1'b1;
            OP_BLANK: begin
              // Locked block never reports blank
              erase_set = !lock_bit || !i_blank_result;
            end
            OP_ERASE: begin
              if (i_verify_fail) begin
                erase_set = 1'b1;
              end else if (lock_bit || i_lock_disable_bit) begin
                lock_set = 1'b1;
              end
            end
            OP_PROGRAM: prog_set = i_verify_fail;
            default:    state_next = ST_READY;
          endcase
        end
      end
      ST_SUSPEND: begin
        if (i_forced_stop) begin
          timer_load  = 1'b1;
          timer_count = TIMER_W'(RESTART_CYCLES);
          state_next  = ST_RESTART;
        end else if (!i_suspend_request_bit) begin
          state_next = ST_BUSY;
        end
      end
      ST_RESTART: begin
        if (timer_expired) begin
          state_next       = ST_READY;
          status_mode_next = 1'b0;
        end
      end
      default: state_next = ST_READY;
    endcase
  end

  // Sequencer state
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_reg       <= ST_READY;
      pend_reg        <= OP_NONE;
      block_reg       <= '0;
      status_mode_reg <= 1'b0;
    end else begin
      state_reg       <= state_next;
      pend_reg        <= pend_next;
      block_reg       <= block_next;
      status_mode_reg <= status_mode_next;
    end
  end

  // First-cycle address, compared for lock program
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      first_addr_reg <= '0;
    end else if (state_reg == ST_READY && cmd_wr) begin
      first_addr_reg <= i_bus_addr;
    end
  end

  // Array start and kind are registered from start_op; a locked erase or program
  // still starts the array and is flagged one cycle after o_array_start
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      kind_reg  <= OP_NONE;
      start_reg <= 1'b0;
    end else begin
      start_reg <= start_op;
      if (start_op) begin
        kind_reg <= pend_next;
      end
    end
  end

  // Error flags: a set in the same cycle as a clear wins
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      prog_err_reg  <= STS_PROG_RST;
      erase_err_reg <= STS_ERASE_RST;
    end else if (state_reg == ST_RESTART) begin
      prog_err_reg  <= STS_PROG_RST;
      erase_err_reg <= STS_ERASE_RST;
    end else begin
      prog_err_reg  <= (prog_err_reg && !err_clr) || prog_set ||
                       (start_reg && kind_reg == OP_PROGRAM && !lock_bit &&
                        !i_lock_disable_bit);
      erase_err_reg <= (erase_err_reg && !err_clr) || erase_set ||
                       (start_reg && kind_reg == OP_ERASE && !lock_bit &&
                        !i_lock_disable_bit);
    end
  end

  // Lock state flag follows the selected block on a lock read
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      lock_state_reg <= LOCK_STATE_RST;
    end else if (lock_load) begin
      lock_state_reg <= lock_bit;
    end
  end

  // Suspend latency counter, restarts whenever the request drops
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      lat_cnt_reg <= '0;
    end else if (state_reg != ST_BUSY || !i_suspend_request_bit) begin
      lat_cnt_reg <= '0;
    end else if (!lat_done) begin
      lat_cnt_reg <= lat_cnt_reg + LAT_W'(1);
    end
  end

  // Read data: status byte at even addresses in status mode
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rdata_reg <= '0;
    end else if (i_bus_re) begin
      if (status_mode_reg && !i_bus_addr[0]) begin
        rdata_reg <= {8'h00, o_flash_sequencer_status_byte};
      end else begin
        rdata_reg <= i_array_rdata;
      end
    end
  end

  // Status outputs
  always_comb begin
    o_flash_sequencer_status_byte                = 8'h00;
    o_flash_sequencer_status_byte[STS_PROG_BIT]  = prog_err_reg;
    o_flash_sequencer_status_byte[STS_ERASE_BIT] = erase_err_reg;
    o_flash_sequencer_status_byte[STS_READY_BIT] = o_sequencer_ready_flag;
  end

  // Suspend shows ready so software may touch other blocks
  assign o_sequencer_ready_flag = (state_reg != ST_BUSY) &&
                                  (state_reg != ST_RESTART);
  assign o_program_error_flag   = prog_err_reg;
  assign o_erase_error_flag     = erase_err_reg;
  assign o_lock_state_flag      = lock_state_reg;
  assign o_suspended            = (state_reg == ST_SUSPEND);
  assign o_bus_rdata            = rdata_reg;
  assign o_array_start          = start_reg;
  assign o_array_kind           = kind_reg;
  assign o_array_block          = block_reg;
  // CPU-halting mode stops the watchdog only while the array works
  assign o_watchdog_count_en    = !i_rewrite_mode_select_bit ||
                                  (state_reg != ST_BUSY);

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);

  property p_reserved_zero;
    o_flash_sequencer_status_byte[3:0] == 4'h0 && !o_flash_sequencer_status_byte[6];
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("reserved status bits not zero");

  property p_busy_not_ready;
    state_reg == ST_WAIT2 && cmd_wr && code == CMD_CONFIRM && top_addr &&
      pend_reg == OP_BLANK |=> !o_sequencer_ready_flag && o_flash_sequencer_status_byte[7] == 1'b0;
  endproperty
  a_busy_not_ready: assert property (p_busy_not_ready)
    else $error("ready not low after operation start");

  property p_clear_status;
    state_reg == ST_READY && cmd_wr && code == CMD_CLEAR_STATUS
      |=> !o_program_error_flag && !o_erase_error_flag;
  endproperty
  a_clear_status: assert property (p_clear_status)
    else $error("clear status left an error flag");

  property p_abort_second;
    state_reg == ST_WAIT2 && cmd_wr && code == CMD_READ_ARRAY
      |=> state_reg == ST_READY && !status_mode_reg && $stable(o_erase_error_flag);
  endproperty
  a_abort_second: assert property (p_abort_second)
    else $error("FFh in second cycle did not return to array reads");

  property p_seq_error;
    state_reg == ST_WAIT2 && cmd_wr && code != CMD_CONFIRM && code != CMD_READ_ARRAY
      |=> o_program_error_flag && o_erase_error_flag && o_sequencer_ready_flag;
  endproperty
  a_seq_error: assert property (p_seq_error)
    else $error("bad second cycle did not flag sequence error");

  property p_forced_stop;
    state_reg == ST_BUSY && i_forced_stop
      |=> state_reg == ST_RESTART && !o_sequencer_ready_flag ##1 !o_erase_error_flag;
  endproperty
  a_forced_stop: assert property (p_forced_stop)
    else $error("forced stop did not abort operation");

  property p_resume;
    state_reg == ST_SUSPEND && !i_suspend_request_bit && !i_forced_stop
      |=> state_reg == ST_BUSY && !o_suspended;
  endproperty
  a_resume: assert property (p_resume)
    else $error("clearing suspend request did not resume");

  property p_no_early_suspend;
    state_reg == ST_BUSY && $rose(i_suspend_request_bit) |=> !o_suspended [*3];
  endproperty
  a_no_early_suspend: assert property (p_no_early_suspend)
    else $error("suspended before latency elapsed");

  property p_blank_locked;
    op_done && kind_reg == OP_BLANK && !lock_bit |=> o_erase_error_flag;
  endproperty
  a_blank_locked: assert property (p_blank_locked)
    else $error("blank check on locked block not flagged");

  property p_disabled_ignored;
    i_bus_we && !i_rewrite_enable_bit && state_reg == ST_READY |=> state_reg == ST_READY;
  endproperty
  a_disabled_ignored: assert property (p_disabled_ignored)
    else $error("command accepted without rewrite enable");

  property p_status_read;
    state_reg == ST_READY && cmd_wr && code == CMD_READ_STATUS ##1 !cmd_wr ##1 i_bus_re
      && !i_bus_addr[0] |=> o_bus_rdata == {8'h00, $past(o_flash_sequencer_status_byte)};
  endproperty
  a_status_read: assert property (p_status_read)
    else $error("read after 70h did not return status");
endmodule : flash_lock_blank_status_sequencer

// ==== sim/cpu_bus_model.sv ====
// CPU-side model issuing one-cycle flash write and read strobes
module cpu_bus_model (
  // Clock
  input  wire logic        i_clk,
  // Bus drive
  output logic             o_we,
  output logic             o_re,
  output logic [19:0]      o_addr,
  output logic [15:0]      o_wdata
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle bus at time zero
  initial begin
    o_we = 1'b0;
    o_re = 1'b0;
    o_addr = 20'h00000;
    o_wdata = 16'h0000;
  end
  // After a write the data lines show the inverse, after a read the address lines, so stale values never look valid
  task automatic wr(input logic [19:0] a, input logic [15:0] d);
    @(posedge i_clk);
    o_we <= 1'b1;
    o_addr <= a;
    o_wdata <= d;
    @(posedge i_clk);
    o_we <= 1'b0;
    o_wdata <= ~d;
  endtask : wr
  task automatic rd(input logic [19:0] a);
    @(posedge i_clk);
    o_re <= 1'b1;
    o_addr <= a;
    @(posedge i_clk);
    o_re <= 1'b0;
    o_addr <= ~a;
  endtask : rd
endmodule : cpu_bus_model

// ==== sim/flash_lock_blank_status_sequencer_tb.sv ====
// Self-checking bench for the flash command sequencer
module flash_lock_blank_status_sequencer_tb;
  import flash_seq_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0, rst_b = 1'b0, we, re, blank = 1'b1, lkd = 1'b0, stop = 1'b0;
  logic        rdy, perr, eerr, lks, wd;
  logic        en = 1'b1, msel = 1'b0, vf = 1'b0, sus = 1'b0, susp, start;
  logic [3:0]  blk;
  op_kind_t    kind;
  logic [19:0] addr;
  logic [15:0] wdata, rdata;
  logic [7:0]  sts;
  int          err_count = 0, n_checks = 0, cyc = 0;
  cpu_bus_model i_cpu_bus_model (.i_clk(clk), .o_we(we), .o_re(re), .o_addr(addr),
    .o_wdata(wdata));
  flash_lock_blank_status_sequencer i_flash_lock_blank_status_sequencer (
    .i_clk(clk), .i_rst_b(rst_b), .i_bus_we(we), .i_bus_re(re), .i_bus_addr(addr),
    .i_bus_wdata(wdata), .o_bus_rdata(rdata), .i_array_rdata(16'h5A3C),
    .i_blank_result(blank), .i_verify_fail(vf), .o_array_start(start), .o_array_kind(kind),
    .o_array_block(blk), .i_rewrite_enable_bit(en), .i_rewrite_mode_select_bit(msel),
    .i_lock_disable_bit(lkd), .i_suspend_request_bit(sus), .i_forced_stop(stop),
    .o_sequencer_ready_flag(rdy), .o_program_error_flag(perr),
    .o_erase_error_flag(eerr), .o_lock_state_flag(lks), .o_suspended(susp),
    .o_flash_sequencer_status_byte(sts), .o_watchdog_count_en(wd));
  // Clock and hang guard; ops take 200 cycles, so 20000 is ample
  always #5 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc > 20000) begin
      err_count++;
      test_done();
    end
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic test_done;
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : test_done
  // Same top address in both cycles, then ready must drop
  task automatic start2(input logic [7:0] c, input logic [3:0] b);
    i_cpu_bus_model.wr({4'h0, b, 12'hFFE}, {8'h00, c});
    i_cpu_bus_model.wr({4'h0, b, 12'hFFE}, 16'h00D0);
    #1 check(rdy, 1'b0);
    check(start, 1'b1);
    check(blk, b);
  endtask : start2
  // Bounded wait; results read only once ready
  task automatic wait_ready;
    int n;
    n = 0;
    while (rdy !== 1'b1 && n < 400) begin
      @(posedge clk);
      n++;
    end
    #1 check(rdy, 1'b1);
  endtask : wait_ready
  task automatic clear_and_read(input logic [15:0] exp);
    i_cpu_bus_model.rd(20'h00010);
    #1 check(rdata, exp);
    i_cpu_bus_model.wr(20'h00000, 16'h0050);
    #1 check(sts, 8'h80);
  endtask : clear_and_read
  task automatic t_blank;
    blank <= 1'b0;
    start2(8'h25, 4'h1);
    wait_ready();
    clear_and_read(16'h00A0);
  endtask : t_blank
  task automatic t_lock;
    start2(8'h77, 4'h2);
    wait_ready();
    check(perr, 1'b0);
    start2(8'h71, 4'h2);
    wait_ready();
    check(lks, 1'b0);
    lkd <= 1'b1;
    blank <= 1'b1;
    start2(8'h25, 4'h2);
    wait_ready();
    clear_and_read(16'h00A0);
  endtask : t_lock
  task automatic t_sequence;
    i_cpu_bus_model.wr(20'h00000, 16'h0020);
    i_cpu_bus_model.wr(20'h03FFE, 16'h0012);
    #1 clear_and_read(16'h00B0);
    i_cpu_bus_model.wr(20'h00000, 16'h0020);
    i_cpu_bus_model.wr(20'h03FFE, 16'h00FF);
    i_cpu_bus_model.rd(20'h00010);
    #1 check(rdata, 16'h5A3C);
    i_cpu_bus_model.wr(20'h00000, 16'h0070);
    i_cpu_bus_model.rd(20'h00010);
    #1 check(rdata, 16'h0080);
  endtask : t_sequence
  // Erase error recovery: clear, read lock, disable locks, three failing retries, then a clean erase
  task automatic t_recover;
    lkd <= 1'b0;
    start2(8'h20, 4'h2);
    wait_ready();
    clear_and_read(16'h00A0);
    start2(8'h71, 4'h2);
    wait_ready();
    check(lks, 1'b0);
    lkd <= 1'b1;
    vf <= 1'b1;
    repeat (3) begin
      start2(8'h20, 4'h2);
      wait_ready();
      clear_and_read(16'h00A0);
    end
    vf <= 1'b0;
    start2(8'h20, 4'h2);
    wait_ready();
    check(eerr, 1'b0);
  endtask : t_recover
  // Suspend after the default 20-cycle latency, then resume; CPU-halting mode
  task automatic t_suspend;
    msel <= 1'b1;
    start2(8'h20, 4'h4);
    check(kind, OP_ERASE);
    check(wd, 1'b0);
    @(posedge clk) sus <= 1'b1;
    repeat (20) @(posedge clk);
    #1 check(susp, 1'b0);
    @(posedge clk);
    #1 check(susp, 1'b1);
    check(rdy, 1'b1);
    check(wd, 1'b1);
    sus <= 1'b0;
    @(posedge clk);
    #1 check(susp, 1'b0);
    check(rdy, 1'b0);
    msel <= 1'b0;
    wait_ready();
  endtask : t_suspend
  // A 70h written with rewrite disabled must leave array reads in place
  task automatic t_disable;
    i_cpu_bus_model.wr(20'h00000, 16'h00FF);
    en <= 1'b0;
    i_cpu_bus_model.wr(20'h00000, 16'h0070);
    en <= 1'b1;
    i_cpu_bus_model.rd(20'h00010);
    #1 check(rdata, 16'h5A3C);
  endtask : t_disable
  task automatic t_stop;
    start2(8'h20, 4'h3);
    @(posedge clk) stop <= 1'b1;
    @(posedge clk) stop <= 1'b0;
    #1 check(rdy, 1'b0);
    wait_ready();
    i_cpu_bus_model.rd(20'h00010);
    #1 check(rdata, 16'h5A3C);
  endtask : t_stop
  // Main sequence: reset two cycles, then each scenario
  initial begin
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    #1 check(sts, 8'h80);
    check(wd, 1'b1);
    t_blank();
    t_lock();
    t_sequence();
    t_recover();
    t_stop();
    t_suspend();
    t_disable();
    test_done();
  end
endmodule : flash_lock_blank_status_sequencer_tb
